//--- logic/fcl_map.svh
// Register indices, field positions, reset values and timing of the fan control limit block
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH

// Register indices; the byte address is four times the index
`define FCL_IDX_CTRL 8'h40
`define FCL_IDX_STATUS 8'h41
`define FCL_IDX_ACOUSTIC 8'h42
`define FCL_IDX_FLOOR1 8'h64
`define FCL_IDX_FLOOR2 8'h65
`define FCL_IDX_FLOOR3 8'h66
`define FCL_IDX_START_R1 8'h67
`define FCL_IDX_START_LOC 8'h68
`define FCL_IDX_START_R2 8'h69
`define FCL_IDX_CRIT_R1 8'h6A
`define FCL_IDX_CRIT_LOC 8'h6B
`define FCL_IDX_CRIT_R2 8'h6C
`define FCL_IDX_HYST_R1_LOC 8'h6D
`define FCL_IDX_HYST_R2 8'h6E
`define FCL_IDX_TEST 8'h6F
`define FCL_IDX_OFFSET_R1 8'h70

// Reset values
`define FCL_RST_FLOOR 8'h80
`define FCL_RST_START 8'h5A
`define FCL_RST_CRIT 8'h64
`define FCL_RST_HYST_R1_LOC 8'h44
`define FCL_RST_HYST_R2 8'h40
`define FCL_RST_ZERO 8'h00

// Field positions
`define FCL_CTRL_LOCK_BIT 0
`define FCL_CTRL_AUTO_BIT 1
`define FCL_ACOU_EN_BIT 7
`define FCL_ACOU_RATE_HI 6
`define FCL_ACOU_RATE_LO 4
`define FCL_TEST_ON_BIT 0

// Special values
`define FCL_CRIT_DISABLE 8'h80
`define FCL_CRIT_RELEASE_C 9'h004
`define FCL_DUTY_FULL 8'hFF

// Timing: one ramp slot, slowest code steps 1 count per slot (33% to 100% in 35 s)
`define FCL_RAMP_SLOT_MS 205
`define FCL_CLK_KHZ 100000

`endif

//--- logic/fcl_pkg.sv
// Types shared by the fan control limit block
package fcl_pkg;

   // Corrected or raw readings of the three temperature channels, 1 C per LSB
   typedef struct packed {
      logic [7:0] remote_two;
      logic [7:0] local_temp;
      logic [7:0] remote_one;
   } fcl_temps_type;

   // Bus answer state
   typedef enum logic [1:0] {
      FCL_IDLE = 2'b01,
      FCL_ANSWER = 2'b10
   } fcl_bus_state_type;

endpackage : fcl_pkg

//--- logic/fcl_top.sv
// Fan control limit registers, fail-safe and floor duty logic behind an APB slave
//
// Function
// R01: With enable bit 7 set, fan output 2 ramps gradually toward each new duty.
// R02: Software should disable spin-up time on outputs using gradual ramping.
// R03: Floor duty register sets lowest automatic duty, linear 0x00 off to 0xFF full.
// R04: Floor duty registers ignore writes while automatic fan control mode is on.
// R05: Above start temperature the fan runs at floor duty, rising with temperature span.
// R06: After lock is set, start, critical, test and offset registers ignore writes.
// R07: Any channel above its critical limit forces all fan outputs to full duty.
// R08: A critical limit of 0x80 disables the fail-safe for that channel.
// R09: Full duty holds until temperature falls below critical limit minus 4 C.
// R10: Below start temperature the fan stays at floor until start minus hysteresis.
// R11: Hysteresis is a 4-bit field, 0 to 15 C at 1 C per step.
// R12: Software should program at least 4 C of hysteresis.
// R13: Test enable bit 0 set enters pin tree test mode; clearing leaves it.
// R14: Software must not write bits 7 to 1 of the test enable register.
// R15: Signed offset register is added to the first remote reading, 1 C per LSB.
// R16: Three-bit ramp field selects step size; slowest takes 35 s from 33% to 100%.
// R17: Start and critical limits compare with readings at 1 C per LSB.
`timescale 1ns/1ps
`include "fcl_map.svh"

module fcl_top #(
   parameter int unsigned RAMP_SLOT_CYCLES = `FCL_RAMP_SLOT_MS * `FCL_CLK_KHZ
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fcl_pkg::fcl_temps_type temps_raw,
   input wire logic [2:0][3:0] temperature_span,
   output logic [7:0] fan_drive_output_1,
   output logic [7:0] fan_drive_output_2,
   output logic [7:0] fan_drive_output_3,
   output logic pin_tree_test_on,
   output fcl_pkg::fcl_temps_type temps_corrected
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Duty counts added per ramp slot for each rate code
   function automatic logic [7:0] fcl_step(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      unique case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h05;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0C;
         3'h6: s = 8'h18;
         3'h7: s = 8'h30;
      endcase
      return s;
   endfunction : fcl_step

   // Saturate a 13-bit sum to one duty byte
   function automatic logic [7:0] fcl_sat(input logic [12:0] v);
      return (v > 13'h00FF) ? `FCL_DUTY_FULL : v[7:0];
   endfunction : fcl_sat

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [2:0][7:0] floor_q;
   logic [2:0][7:0] start_q;
   logic [2:0][7:0] crit_q;
   logic [7:0] hyst_a_q;
   logic [7:0] hyst_b_q;
   logic test_q;
   logic [7:0] offset_q;
   logic [7:0] acoustic_q;
   logic lock_q;
   logic auto_q;
   logic [2:0] active_q;
   logic [2:0] tripped_q;
   logic [7:0] duty1_q;
   logic [7:0] duty2_q;
   logic [7:0] duty3_q;
   logic [31:0] slot_cnt_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   fcl_pkg::fcl_temps_type corr_q;
   fcl_pkg::fcl_bus_state_type bus_q;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire [9:0] idx = paddr[11:2];
   wire aligned = (paddr[1:0] == 2'b00);
   wire setup = psel && !penable;
   wire wr_go = psel && penable && pwrite && pready_q && !pslverr_q;
   wire hit_ctrl = (idx == {2'b00, `FCL_IDX_CTRL});
   wire hit_status = (idx == {2'b00, `FCL_IDX_STATUS});
   wire hit_acou = (idx == {2'b00, `FCL_IDX_ACOUSTIC});
   wire hit_hyst_a = (idx == {2'b00, `FCL_IDX_HYST_R1_LOC});
   wire hit_hyst_b = (idx == {2'b00, `FCL_IDX_HYST_R2});
   wire hit_test = (idx == {2'b00, `FCL_IDX_TEST});
   wire hit_offset = (idx == {2'b00, `FCL_IDX_OFFSET_R1});
   wire [2:0] hit_floor;
   wire [2:0] hit_start;
   wire [2:0] hit_crit;
   wire hit_any;
   wire [7:0] rd_byte;

   // Status is read-only; writes to it are answered and dropped
   assign hit_any = aligned && (hit_ctrl || hit_status || hit_acou || hit_hyst_a || hit_hyst_b
      || hit_test || hit_offset || (|hit_floor) || (|hit_start) || (|hit_crit));

   // Readings and limits are all whole degrees, so no scaling on compare
   wire [2:0][7:0] temp_ch = {corr_q.remote_two, corr_q.local_temp, corr_q.remote_one}; // R17
   wire [2:0][3:0] hyst_ch = {hyst_b_q[7:4], hyst_a_q[3:0], hyst_a_q[7:4]}; // R11
   wire [2:0][7:0] target_ch;
   wire [2:0] trip_now;

   assign rd_byte =
      hit_ctrl ? {6'h00, auto_q, lock_q} :
      hit_status ? {2'b00, active_q, tripped_q} :
      hit_acou ? acoustic_q :
      hit_hyst_a ? hyst_a_q :
      hit_hyst_b ? hyst_b_q :
      hit_test ? {7'h00, test_q} :
      hit_offset ? offset_q :
      hit_floor[0] ? floor_q[0] :
      hit_floor[1] ? floor_q[1] :
      hit_floor[2] ? floor_q[2] :
      hit_start[0] ? start_q[0] :
      hit_start[1] ? start_q[1] :
      hit_start[2] ? start_q[2] :
      hit_crit[0] ? crit_q[0] :
      hit_crit[1] ? crit_q[1] :
      hit_crit[2] ? crit_q[2] : 8'h00;

   // ----------------------------------------------------------------
   // Temperature correction
   // ----------------------------------------------------------------
   wire signed [9:0] r1_sum = $signed({2'b00, temps_raw.remote_one})
      + $signed({{2{offset_q[7]}}, offset_q}); // R15
   // Clamp instead of wrapping so a large offset cannot turn a hot reading cold
   wire [7:0] r1_corr = r1_sum[9] ? 8'h00 : (r1_sum[8] ? 8'hFF : r1_sum[7:0]);

   // ----------------------------------------------------------------
   // Per-channel limit logic
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_ch
         wire [7:0] t = temp_ch[g];
         wire above_start = t > start_q[g];
         // Nine bits so a start below the hysteresis never wraps to a high level
         wire [8:0] release_lvl = {1'b0, start_q[g]} - {5'h00, hyst_ch[g]};
         wire at_release = !release_lvl[8] && ({1'b0, t} <= release_lvl); // R10
         wire crit_on = crit_q[g] != `FCL_CRIT_DISABLE; // R08
         wire [8:0] crit_rel = {1'b0, crit_q[g]} - `FCL_CRIT_RELEASE_C;
         wire below_rel = !crit_rel[8] && ({1'b0, t} < crit_rel); // R09
         wire [7:0] excess = above_start ? t - start_q[g] : 8'h00;
         wire [12:0] rise = {1'b0, excess} * {9'h000, temperature_span[g]};
         assign hit_floor[g] = idx == 10'(`FCL_IDX_FLOOR1 + g);
         assign hit_start[g] = idx == 10'(`FCL_IDX_START_R1 + g);
         assign hit_crit[g] = idx == 10'(`FCL_IDX_CRIT_R1 + g);
         assign trip_now[g] = crit_on && (t > crit_q[g]); // R07
         // Off below the band; floor plus span slope above start
         assign target_ch[g] = active_q[g] ? fcl_sat({5'h00, floor_q[g]} + rise) : 8'h00; // R03 R05

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               active_q[g] <= 1'b0;
               tripped_q[g] <= 1'b0;
            end
            else
            begin
               if (above_start)
                  active_q[g] <= 1'b1; // R05
               else if (at_release)
                  active_q[g] <= 1'b0; // R10
               if (!crit_on)
                  tripped_q[g] <= 1'b0; // R08
               else if (trip_now[g])
                  tripped_q[g] <= 1'b1; // R07
               else if (below_rel)
                  tripped_q[g] <= 1'b0; // R09
            end
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               floor_q[g] <= `FCL_RST_FLOOR;
               start_q[g] <= `FCL_RST_START;
               crit_q[g] <= `FCL_RST_CRIT;
            end
            else
            begin
               if (wr_go && hit_floor[g] && !auto_q)
                  floor_q[g] <= pwdata[7:0]; // R04
               if (wr_go && hit_start[g] && !lock_q)
                  start_q[g] <= pwdata[7:0]; // R06
               if (wr_go && hit_crit[g] && !lock_q)
                  crit_q[g] <= pwdata[7:0]; // R06
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Fan duty outputs
   // ----------------------------------------------------------------
   // Fail-safe takes priority and bypasses the ramp so cooling is immediate
   wire force_full = |tripped_q; // R07 R09
   wire ramp_en = acoustic_q[`FCL_ACOU_EN_BIT];
   wire [7:0] step = fcl_step(acoustic_q[`FCL_ACOU_RATE_HI:`FCL_ACOU_RATE_LO]); // R16
   wire slot_end = slot_cnt_q >= RAMP_SLOT_CYCLES - 32'd1;
   wire [7:0] up_gap = target_ch[1] - duty2_q;
   wire [7:0] down_gap = duty2_q - target_ch[1];
   wire [7:0] ramp_next =
      (target_ch[1] > duty2_q) ? ((up_gap > step) ? duty2_q + step : target_ch[1]) :
      ((down_gap > step) ? duty2_q - step : target_ch[1]);

   // Free-running slot: a new target waits at most one slot before the first step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         slot_cnt_q <= 32'd0;
      else
         slot_cnt_q <= slot_end ? 32'd0 : slot_cnt_q + 32'd1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         duty1_q <= 8'h00;
         duty2_q <= 8'h00;
         duty3_q <= 8'h00;
      end
      else
      begin
         // Outputs 1 and 3 follow their target directly; only output 2 ramps
         duty1_q <= force_full ? `FCL_DUTY_FULL : target_ch[0];
         duty3_q <= force_full ? `FCL_DUTY_FULL : target_ch[2];
         if (force_full)
            duty2_q <= `FCL_DUTY_FULL;
         else if (!ramp_en)
            duty2_q <= target_ch[1];
         else if (slot_end)
            duty2_q <= ramp_next; // R01
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         corr_q <= '0;
      else
         corr_q <= '{remote_two: temps_raw.remote_two, local_temp: temps_raw.local_temp, remote_one: r1_corr};
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hyst_a_q <= `FCL_RST_HYST_R1_LOC;
         hyst_b_q <= `FCL_RST_HYST_R2;
      end
      else if (wr_go)
      begin
         if (hit_hyst_a)
            hyst_a_q <= pwdata[7:0]; // R11
         if (hit_hyst_b)
            hyst_b_q <= pwdata[7:0]; // R11
      end
   end

   // Locked registers drop writes silently; the bus still answers without error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         test_q <= 1'b0;
         offset_q <= `FCL_RST_ZERO;
      end
      else if (wr_go && !lock_q)
      begin
         if (hit_test)
            test_q <= pwdata[`FCL_TEST_ON_BIT]; // R13 R06
         if (hit_offset)
            offset_q <= pwdata[7:0]; // R06
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acoustic_q <= `FCL_RST_ZERO;
      else if (wr_go && hit_acou)
         acoustic_q <= pwdata[7:0]; // R01
   end

   // Auto mode freezes the floor duties; lock only sets and falls only at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lock_q <= 1'b0;
         auto_q <= 1'b0;
      end
      else if (wr_go && hit_ctrl)
      begin
         lock_q <= lock_q | pwdata[`FCL_CTRL_LOCK_BIT];
         auto_q <= pwdata[`FCL_CTRL_AUTO_BIT];
      end
   end

   // ----------------------------------------------------------------
   // APB answer: one access cycle, data prepared in the setup cycle
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_q <= fcl_pkg::FCL_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         unique case (bus_q)
            fcl_pkg::FCL_IDLE:
               if (setup)
               begin
                  bus_q <= fcl_pkg::FCL_ANSWER;
                  pready_q <= 1'b1;
                  pslverr_q <= !hit_any;
                  prdata_q <= (hit_any && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
               end
            fcl_pkg::FCL_ANSWER:
            begin
               bus_q <= fcl_pkg::FCL_IDLE;
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
               prdata_q <= 32'h0000_0000;
            end
            default:
               bus_q <= fcl_pkg::FCL_IDLE;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign fan_drive_output_1 = duty1_q;
   assign fan_drive_output_2 = duty2_q;
   assign fan_drive_output_3 = duty3_q;
   assign pin_tree_test_on = test_q;
   assign temps_corrected = corr_q;

endmodule : fcl_top

//--- tb/fcl_checker.sv
// Port assertions for the fan control limit block
`timescale 1ns/1ps
module fcl_checker #(
   parameter int unsigned RAMP_SLOT_CYCLES = 8
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire fcl_pkg::fcl_temps_type temps_raw,
   input wire logic [2:0][3:0] temperature_span,
   input wire logic [7:0] fan_drive_output_1,
   input wire logic [7:0] fan_drive_output_2,
   input wire logic [7:0] fan_drive_output_3,
   input wire logic pin_tree_test_on,
   input wire fcl_pkg::fcl_temps_type temps_corrected
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [9:0] idx = paddr[11:2];
   wire logic mapped = (idx >= 10'h040 && idx <= 10'h042) || (idx >= 10'h064 && idx <= 10'h070);
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_ready_prompt: assert property (psel && !penable |=> pready) else $error("ready late");
   a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   a_map_err: assert property (pready |-> pslverr == (!mapped || paddr[1:0] != 2'b00))
      else $error("error flag wrong");
   a_test_cause: assert property ($changed(pin_tree_test_on) |-> $past(pready && pwrite && paddr == 12'h1BC))
      else $error("test mode changed alone");
   a_pass_temps: assert property ($past(presetn) |-> temps_corrected.local_temp == $past(temps_raw.local_temp)
      && temps_corrected.remote_two == $past(temps_raw.remote_two)) else $error("reading path wrong");
   c_write: cover property (pready && pwrite && !pslverr);
   c_error: cover property (pslverr);
   c_full: cover property (fan_drive_output_1 == 8'hFF && fan_drive_output_3 == 8'hFF);
endmodule : fcl_checker

//--- tb/fcl_top_tb.sv
// Self-checking testbench for the fan control limit block
`timescale 1ns/1ps
module fcl_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_tree_test_on, err_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   fcl_pkg::fcl_temps_type temps_raw, temps_corrected;
   logic [2:0][3:0] temperature_span;
   logic [7:0] fan_drive_output_1, fan_drive_output_2, fan_drive_output_3;
   logic [7:0] m [0:255];
   logic [15:0] seed;
   int errors, num_checks, cyc;
   fcl_top #(.RAMP_SLOT_CYCLES(8)) fcl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .temps_raw(temps_raw), .temperature_span(temperature_span),
      .fan_drive_output_1(fan_drive_output_1), .fan_drive_output_2(fan_drive_output_2),
      .fan_drive_output_3(fan_drive_output_3), .pin_tree_test_on(pin_tree_test_on),
      .temps_corrected(temps_corrected));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         errors++;
         results;
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   task automatic rst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 256; i++) m[i] = 8'h00;
      for (int i = 8'h64; i <= 8'h6C; i++) m[i] = (i < 8'h67) ? 8'h80 : (i < 8'h6A) ? 8'h5A : 8'h64;
      m[8'h6D] = 8'h44;
      m[8'h6E] = 8'h40;
   endtask : rst
   // -------------------------------------------------------------
   // APB master: release one edge before the next setup
   // -------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      seed = lfsr(seed);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {seed, seed[7:0], d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic fl, lk;
      fl = i >= 8'h64 && i <= 8'h66;
      lk = (i >= 8'h67 && i <= 8'h6C) || i == 8'h6F || i == 8'h70;
      apb(1'b1, {2'b00, i, 2'b00}, d);
      if (!(fl && m[8'h40][1]) && !(lk && m[8'h40][0]))
         m[i] = (i == 8'h6F) ? {7'h00, d[0]} : (i == 8'h40) ? {6'h00, d[1], d[0] | m[i][0]} : d;
   endtask : wr
   task automatic rdc(input logic [7:0] i);
      apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
      chk(rd_q, {24'h0, m[i]});
   endtask : rdc
   task automatic outs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      repeat (4) @(posedge pclk);
      chk({fan_drive_output_1, fan_drive_output_2, fan_drive_output_3}, {8'h00, a, b, c});
   endtask : outs
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      temps_raw = '0;
      temperature_span = 12'h200;
      seed = 16'd62849;
      rst;
      for (int i = 8'h64; i <= 8'h70; i++) rdc(i[7:0]);
      for (int i = 8'h64; i <= 8'h70; i++) wr(i[7:0], (i == 8'h6F) ? {7'h00, seed[0]} : seed[7:0]);
      for (int i = 8'h64; i <= 8'h70; i++) rdc(i[7:0]);
      apb(1'b0, 12'h140, 8'h00);
      chk({rd_q[7:0], 7'h00, err_q}, 32'h1);
      apb(1'b1, 12'h191, 8'h00);
      chk({31'h0, err_q}, 32'h1);
      wr(8'h6F, 8'h01);
      @(posedge pclk);
      chk({31'h0, pin_tree_test_on}, 32'h1);
      wr(8'h6F, 8'h00);
      @(posedge pclk);
      chk({31'h0, pin_tree_test_on}, 32'h0);
      wr(8'h70, 8'hFB);
      temps_raw <= {8'd0, 8'd0, 8'd100};
      repeat (3) @(posedge pclk);
      chk({24'h0, temps_corrected.remote_one}, 32'd95);
      temps_raw <= {8'd0, 8'd0, 8'd2};
      repeat (3) @(posedge pclk);
      chk({24'h0, temps_corrected.remote_one}, 32'd0);
      rst;
      temps_raw <= '0;
      wr(8'h66, 8'h40);
      wr(8'h69, 8'h32);
      temps_raw <= {8'd60, 8'd0, 8'd0};
      outs(8'h00, 8'h00, 8'h54);
      temps_raw <= {8'd48, 8'd0, 8'd0};
      outs(8'h00, 8'h00, 8'h40);
      temps_raw <= {8'd46, 8'd0, 8'd0};
      outs(8'h00, 8'h00, 8'h00);
      temps_raw <= {8'd0, 8'd101, 8'd0};
      outs(8'hFF, 8'hFF, 8'hFF);
      apb(1'b0, 12'h104, 8'h00);
      chk(rd_q, 32'h12);
      temps_raw <= {8'd0, 8'd96, 8'd0};
      outs(8'hFF, 8'hFF, 8'hFF);
      temps_raw <= {8'd0, 8'd95, 8'd0};
      outs(8'h00, 8'h80, 8'h00);
      wr(8'h6B, 8'h80);
      temps_raw <= {8'd0, 8'd200, 8'd0};
      outs(8'h00, 8'h80, 8'h00);
      wr(8'h42, 8'h80);
      wr(8'h65, 8'h90);
      repeat (4) @(posedge pclk);
      chk({31'h0, fan_drive_output_2 < 8'h90}, 32'h1);
      repeat (160) @(posedge pclk);
      chk({24'h0, fan_drive_output_2}, 32'h90);
      wr(8'h42, 8'hF0);
      wr(8'h65, 8'h20);
      repeat (40) @(posedge pclk);
      chk({24'h0, fan_drive_output_2}, 32'h20);
      wr(8'h40, 8'h02);
      wr(8'h64, 8'h11);
      wr(8'h40, 8'h03);
      for (int i = 8'h67; i <= 8'h70; i++) wr(i[7:0], 8'h01);
      for (int i = 8'h64; i <= 8'h70; i++) rdc(i[7:0]);
      rdc(8'h40);
      chk({31'h0, pin_tree_test_on}, 32'h0);
      results;
   end
endmodule : fcl_top_tb
bind fcl_top fcl_checker #(.RAMP_SLOT_CYCLES(RAMP_SLOT_CYCLES)) fcl_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .temps_raw(temps_raw), .temperature_span(temperature_span),
   .fan_drive_output_1(fan_drive_output_1), .fan_drive_output_2(fan_drive_output_2),
   .fan_drive_output_3(fan_drive_output_3), .pin_tree_test_on(pin_tree_test_on),
   .temps_corrected(temps_corrected));
